/* dv/ssc_peer_model.sv */
// partner: external SPI device, answers as slave or clocks the port as master
module ssc_peer_model
    import ssc_pkg::*;
(
    input  wire logic i_sck,  // shared clock wire
    input  wire logic i_cpol, // idle level in use
    input  wire logic i_sdo,  // port data out
    output logic      o_sck,  // clock when master
    output logic      o_sdi   // data to the port
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] tx = 8'h00, rx = 8'h00;
    logic ph = 1'b0;
    wire lead = i_sck ^ i_cpol;

    assign o_sck = i_cpol ^ ph; // stands at idle level between frames
    assign o_sdi = tx[7];
    always @(posedge lead)
        rx <= {rx[6:0], i_sdo};
    // a sent bit is not held: the line walks a changing pattern
    always @(negedge lead)
        tx <= {tx[6:0], ~tx[0]};

    task automatic send(input logic [7:0] b);
        #2 tx = b;
        repeat (16)
            #64 ph = ~ph;
        #64;
    endtask : send
endmodule : ssc_peer_model

/* dv/ssc_port_monitor.sv */
// checker: bus handshake and pin ownership of the serial port
module ssc_port_monitor
    import ssc_pkg::*;
(
    input wire logic         i_clk,          // clock
    input wire logic         i_sys_rst,      // reset
    input wire ssc_wb_req_s  i_wb,           // bus request
    input wire logic         o_wb_ack,       // bus ack
    input wire ssc_spi_out_s o_spi,          // spi drives
    input wire ssc_i2c_out_s o_i2c,          // i2c drives
    input wire logic         o_spi_pins_own, // spi pins held
    input wire logic         o_i2c_pins_own, // i2c pins held
    input wire logic         o_port_event    // start/stop pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    //------
    // shadow of the control byte; a write lands on the ack edge
    //------
    logic [5:0] sh;
    wire [3:0] md = sh[3:0];
    wire on = sh[5];
    wire spi_md = md < 4'h6 || md == MODE_SPI_MBRG;
    wire spi_ms = md < 4'h4 || md == MODE_SPI_MBRG;
    wire i2c_md = md inside {4'h6, 4'h7, 4'h8, 4'hE, 4'hF};
    wire i2c_sl = i2c_md && md != MODE_I2C_M;
    wire evt_md = md == MODE_I2C_S7E || md == MODE_I2C_S10E;

    always_ff @(posedge i_clk)
        if (i_sys_rst)
            sh <= 6'h00;
        else if (i_wb.cyc && i_wb.stb && i_wb.we && i_wb.sel[0] && o_wb_ack && i_wb.adr == ADR_CTRL)
            sh <= i_wb.dat[5:0];

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_req;
        i_wb.cyc && i_wb.stb && !o_wb_ack;
    endsequence
    sequence s_ack_pulse;
        o_wb_ack ##1 !o_wb_ack;
    endsequence

    a_ack_one_pulse: assert property (s_req |=> s_ack_pulse)
        else $error("ack not a single pulse");
    a_ack_has_req: assert property ($rose(o_wb_ack) |-> $past(i_wb.cyc && i_wb.stb))
        else $error("ack without request");
    a_spi_own_map: assert property (o_spi_pins_own == (on && spi_md))
        else $error("spi ownership wrong");
    a_i2c_own_map: assert property (o_i2c_pins_own == (on && i2c_md))
        else $error("i2c ownership wrong");
    a_rsvd_quiet: assert property (!spi_md && !i2c_md |-> !o_spi.sck_oe && !o_spi.sdo_oe
        && !o_i2c.scl_oe && !o_i2c.sda_oe)
        else $error("reserved mode drives pins");
    a_spi_pins_free: assert property (!o_spi_pins_own |-> !o_spi.sck_oe && !o_spi.sdo_oe)
        else $error("spi pin driven while released");
    a_i2c_pins_free: assert property (!o_i2c_pins_own |-> !o_i2c.scl_oe && !o_i2c.sda_oe)
        else $error("i2c pin driven while released");
    a_slave_stretch: assert property (o_i2c_pins_own && i2c_sl |-> o_i2c.scl_oe == !sh[4])
        else $error("clock stretch wrong");
    a_sck_idle_level: assert property ($rose(o_spi_pins_own) && spi_ms
        |-> o_spi.sck_oe && o_spi.sck == sh[4])
        else $error("sck idle level wrong");
    a_event_mode: assert property (o_port_event |-> $past(on && evt_md))
        else $error("event outside event modes");
endmodule : ssc_port_monitor

bind ssc_port ssc_port_monitor u_mon (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb(i_wb), .o_wb_ack(o_wb_ack), .o_spi(o_spi),
    .o_i2c(o_i2c), .o_spi_pins_own(o_spi_pins_own), .o_i2c_pins_own(o_i2c_pins_own),
    .o_port_event(o_port_event)
);

/* dv/testbench.sv */
// testbench: registers, modes, SPI master and slave, I2C pins of the port
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ssc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, tick = 1'b0, ss_n = 1'b0;
    logic scl_b = 1'b1, sda_b = 1'b1, cpol = 1'b0;
    logic ack, spi_own, i2c_own, evt, p_sck, p_sdi, sck_w;
    logic [31:0] rdat;
    logic [7:0] q;
    ssc_wb_req_s wbq = '0;
    ssc_spi_out_s spi;
    ssc_i2c_out_s i2c;
    int err_count = 0, compares = 0;

    always #4 clk = ~clk;
    always @(posedge clk) tick <= ~tick;
    assign sck_w = spi.sck_oe ? spi.sck : p_sck;

    ssc_port u_dut (.i_clk(clk), .i_sys_rst(rst), .i_wb(wbq), .o_wb_ack(ack), .o_wb_dat(rdat),
        .i_timer_tick(tick), .i_sck(sck_w), .i_sdi(p_sdi), .i_ss_n(ss_n),
        .i_scl(scl_b & ~i2c.scl_oe), .i_sda(sda_b & ~i2c.sda_oe), .o_spi(spi), .o_i2c(i2c),
        .o_spi_pins_own(spi_own), .o_i2c_pins_own(i2c_own), .o_port_event(evt));
    ssc_peer_model u_peer (.i_sck(sck_w), .i_cpol(cpol), .i_sdo(spi.sdo), .o_sck(p_sck),
        .o_sdi(p_sdi));

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic end_of_test;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    // one classic cycle; returns one edge after ack so written state has landed
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        wbq <= '{1'b1, 1'b1, w, a, 4'hF, {24'h0, d}};
        do
        begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        q = rdat[7:0];
        wbq <= '0;
        @(posedge clk);
        if (n >= 40)
        begin
            err_count++;
            end_of_test();
        end
    endtask : wb

    task automatic wait_evt;
        int n;
        n = 0;
        while (evt !== 1'b1 && n < 12)
        begin
            @(posedge clk);
            n++;
        end
        chk("event", n < 12, 1);
    endtask : wait_evt

    task automatic t_regs;
        wb(0, ADR_CTRL, 8'h00);
        chk("ctrl rst", q, CTRL_RST);
        wb(0, ADR_BAUD, 8'h00);
        chk("baud rst", q, BAUD_RST);
        wb(1, ADR_BAUD, 8'h03);
        wb(0, ADR_BAUD, 8'h00);
        chk("baud", q, 8'h03);
        wb(1, 4'h2, 8'h5A);
        wb(0, 4'h2, 8'h00);
        chk("unmapped", q, 8'h00);
    endtask : t_regs

    task automatic t_modes;
        logic [3:0] m;
        for (int i = 0; i < 16; i++)
        begin
            m = 4'(i);
            wb(1, ADR_CTRL, {4'h2, m});
            wb(0, ADR_CTRL, 8'h00);
            chk("mode", q, {4'h2, m});
            chk("spi own", spi_own, m < 4'h6 || m == MODE_SPI_MBRG);
            chk("i2c own", i2c_own, m inside {4'h6, 4'h7, 4'h8, 4'hE, 4'hF});
        end
        wb(1, ADR_CTRL, 8'h04);
        chk("spi off", spi_own, 0);
    endtask : t_modes

    task automatic t_spi_m;
        int n;
        cpol <= 1'b1;
        wb(1, ADR_CTRL, 8'hF1);
        wb(0, ADR_CTRL, 8'h00);
        chk("flags", q, 8'h31);
        chk("sck idle", spi.sck, 1);
        u_peer.tx = 8'h3C;
        wb(1, ADR_BUF, 8'hA5);
        wb(1, ADR_BUF, 8'h11);
        for (n = 0; n < 100; n++)
        begin
            wb(0, ADR_STAT, 8'h00);
            if (q[STAT_BUSY_BIT] === 1'b0)
                break;
        end
        chk("busy", q[STAT_BUSY_BIT], 0);
        chk("sent", u_peer.rx, 8'hA5);
        chk("sck idle", spi.sck, 1);
        wb(0, ADR_BUF, 8'h00);
        chk("recv", q, 8'h3C);
        wb(0, ADR_CTRL, 8'h00);
        chk("collision", q, 8'hB1);
        wb(1, ADR_CTRL, 8'hB1);
        wb(0, ADR_CTRL, 8'h00);
        chk("flag kept", q, 8'hB1);
        wb(1, ADR_CTRL, 8'h31);
        wb(0, ADR_CTRL, 8'h00);
        chk("flag clear", q, 8'h31);
    endtask : t_spi_m

    // nine bytes into a buffer of eight with only control reads between them
    task automatic t_spi_s;
        cpol <= 1'b0;
        wb(1, ADR_CTRL, 8'h05);
        wb(1, ADR_CTRL, 8'h25);
        for (int i = 0; i < 9; i++)
        begin
            u_peer.send(8'h40 + 8'(i));
            @(posedge clk);
            wb(0, ADR_CTRL, 8'h00);
            chk("overflow", q[6], i == 8);
        end
        for (int i = 0; i < 9; i++)
        begin
            wb(0, ADR_BUF, 8'h00);
            chk("rx byte", q, i < 8 ? 8'h40 + i : 8'h00);
        end
        wb(0, ADR_CTRL, 8'h00);
        chk("ovf kept", q, 8'h65);
    endtask : t_spi_s

    task automatic t_i2c;
        wb(1, ADR_CTRL, 8'h26);
        chk("stretch", i2c.scl_oe, 1);
        wb(1, ADR_CTRL, 8'h36);
        chk("release", i2c.scl_oe, 0);
        wb(1, ADR_CTRL, 8'h28);
        chk("master scl", i2c.scl_oe, 0);
        scl_b <= 1'b0;
        repeat (4) @(posedge clk);
        wb(1, ADR_BUF, 8'h55);
        scl_b <= 1'b1;
        wb(0, ADR_CTRL, 8'h00);
        chk("busy bus", q, 8'hA8);
        wb(1, ADR_BUF, 8'hC3);
        repeat (140) @(posedge clk);
        wb(0, ADR_BUF, 8'h00);
        chk("i2c loop", q, 8'hC3);
        wb(1, ADR_CTRL, 8'h3E);
        sda_b <= 1'b0;
        wait_evt();
        @(posedge clk) sda_b <= 1'b1;
        wait_evt();
    endtask : t_i2c

    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_modes();
        t_spi_m();
        t_spi_s();
        t_i2c();
        end_of_test();
    end
endmodule : testbench

/* inc/ssc_pkg.sv */
// package: register map, field layout, mode codes and carriers of the serial port
//----------------------------------------------------------------------
// Operation
//----------------------------------------------------------------------
// Operation
// RQ1: writing the buffer when no transmission can start sets write collision
// RQ2: SPI slave byte arriving while buffer unread sets overflow, byte dropped; here only once the receive FIFO is full
// RQ3: SPI master never sets overflow; each transfer starts from a buffer write
// RQ4: SPI with port enabled owns clock, data out, data in, slave select
// RQ5: I2C with port enabled owns SDA and SCL pins
// RQ6: SPI clock idles at the clock polarity bit level
// RQ7: I2C slave holds SCL low while polarity bit is 0; master ignores it
// RQ8: SPI master clock is system clock /4, /16, /64 or timer tick /2
// RQ9: SPI slave with slave select used, or slave select left free
// RQ10: I2C slave with 7-bit or 10-bit addressing
// RQ11: I2C slave codes that also report start and stop conditions
// RQ12: I2C master clock is system clock /(4*(reload+1)); next code reserved
// RQ13: software keeps the reload value above 2 in I2C mode
// RQ14: software keeps reload nonzero in the baud-driven SPI master mode
// RQ15: status flags stick until software writes zero; writing one sets nothing
// RQ16: reserved mode codes start nothing and leave pins to general I/O
package ssc_pkg;

    //------------------------------------------------------------------
    // register map
    //------------------------------------------------------------------
    localparam logic [3:0] ADR_CTRL = 4'h0;
    localparam logic [3:0] ADR_BUF  = 4'h4;
    localparam logic [3:0] ADR_BAUD = 4'h8;
    localparam logic [3:0] ADR_STAT = 4'hC;

    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h00;

    // status register bit positions
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_AVAIL_BIT = 1;
    localparam int STAT_IDLE_BIT  = 2;

    //------------------------------------------------------------------
    // mode select codes
    //------------------------------------------------------------------
    localparam logic [3:0] MODE_SPI_M4    = 4'h0;
    localparam logic [3:0] MODE_SPI_M16   = 4'h1;
    localparam logic [3:0] MODE_SPI_M64   = 4'h2;
    localparam logic [3:0] MODE_SPI_MTMR  = 4'h3;
    localparam logic [3:0] MODE_SPI_S_SS  = 4'h4;
    localparam logic [3:0] MODE_SPI_S_IO  = 4'h5;
    localparam logic [3:0] MODE_I2C_S7    = 4'h6;
    localparam logic [3:0] MODE_I2C_S10   = 4'h7;
    localparam logic [3:0] MODE_I2C_M     = 4'h8;
    localparam logic [3:0] MODE_SPI_MBRG  = 4'hA;
    localparam logic [3:0] MODE_I2C_S7E   = 4'hE;
    localparam logic [3:0] MODE_I2C_S10E  = 4'hF;

    // half periods of the serial clock, in system clocks
    localparam logic [8:0] HALF_DIV4  = 9'h002;
    localparam logic [8:0] HALF_DIV16 = 9'h008;
    localparam logic [8:0] HALF_DIV64 = 9'h020;

    // synchroniser bit positions
    localparam int PIN_SCK = 0;
    localparam int PIN_SDI = 1;
    localparam int PIN_SS  = 2;
    localparam int PIN_SCL = 3;
    localparam int PIN_SDA = 4;

    //------------------------------------------------------------------
    // types
    //------------------------------------------------------------------
    typedef enum logic {ENG_IDLE = 1'b0, ENG_RUN = 1'b1} ssc_eng_e;

    typedef struct packed {
        logic       write_collision_flag;
        logic       receive_overflow_flag;
        logic       serial_port_enable;
        logic       clock_polarity_hold;
        logic [3:0] port_mode_select;
    } ssc_ctrl_s;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } ssc_wb_req_s;

    typedef struct packed {
        logic sck;
        logic sck_oe;
        logic sdo;
        logic sdo_oe;
    } ssc_spi_out_s;

    typedef struct packed {
        logic scl;
        logic scl_oe;
        logic sda;
        logic sda_oe;
    } ssc_i2c_out_s;

endpackage : ssc_pkg

/* verilog/ssc_fifo.sv */
// module: receive FIFO between the shift engine and the transfer buffer
module ssc_fifo
    import ssc_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)(
    input  wire logic             i_clk,       // system clock
    input  wire logic             i_sys_rst,   // synchronous reset
    input  wire logic             i_in_valid,  // write strobe
    output logic                  o_in_ready,  // not full
    input  wire logic [WIDTH-1:0] i_in_data,   // word in
    output logic                  o_out_valid, // not empty
    input  wire logic             i_out_ready, // pop strobe
    output logic      [WIDTH-1:0] o_out_data   // oldest word
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } fifo_st_s;

    fifo_st_s st;
    fifo_st_s next_st;
    logic     do_wr;
    logic     do_rd;

    assign o_in_ready  = (st.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (st.cnt != '0);
    assign o_out_data  = st.mem[st.rp];
    assign do_wr       = i_in_valid && o_in_ready;
    assign do_rd       = i_out_ready && o_out_valid;

    always_comb
    begin
        next_st = st;
        if (do_wr)
        begin
            next_st.mem[st.wp] = i_in_data;
            next_st.wp = (st.wp == AW'(DEPTH-1)) ? '0 : st.wp + 1'b1;
        end
        if (do_rd)
        begin
            next_st.rp = (st.rp == AW'(DEPTH-1)) ? '0 : st.rp + 1'b1;
        end
        case ({do_wr, do_rd})
            2'b10:   next_st.cnt = st.cnt + 1'b1;
            2'b01:   next_st.cnt = st.cnt - 1'b1;
            default: next_st.cnt = st.cnt;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

endmodule : ssc_fifo

/* verilog/ssc_port.sv */
// module: synchronous serial port control, SPI/I2C pins, Wishbone registers
//
// Local design decisions: the placing of the registers and register access over Wishbone.
module ssc_port
    import ssc_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
)(
    input  wire logic         i_clk,          // 125 MHz system clock
    input  wire logic         i_sys_rst,      // synchronous reset, active high
    input  wire ssc_wb_req_s  i_wb,           // wishbone request
    output logic              o_wb_ack,       // wishbone acknowledge
    output logic       [31:0] o_wb_dat,       // wishbone read data
    input  wire logic         i_timer_tick,   // period timer two output pulse
    input  wire logic         i_sck,          // SPI clock pin in
    input  wire logic         i_sdi,          // SPI data in pin
    input  wire logic         i_ss_n,         // SPI slave select pin, low active
    input  wire logic         i_scl,          // I2C clock pin level
    input  wire logic         i_sda,          // I2C data pin level
    output ssc_spi_out_s      o_spi,          // SPI pin drives and enables
    output ssc_i2c_out_s      o_i2c,          // I2C pin drives and enables
    output logic              o_spi_pins_own, // SPI pins held by the port
    output logic              o_i2c_pins_own, // I2C pins held by the port
    output logic              o_port_event    // start/stop seen, one pulse
);

    //------------------------------------------------------------------
    // state
    //------------------------------------------------------------------
    typedef struct packed {
        ssc_ctrl_s  ctrl;
        logic [7:0] baud;
        logic       ack;
        logic [7:0] rdat;
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] pv;
        ssc_eng_e   eng;
        logic [7:0] shreg;
        logic [2:0] bitn;
        logic       smp;
        logic       sck;
        logic       sdo;
        logic [8:0] divc;
        logic       evt;
    } port_st_s;

    port_st_s st;
    port_st_s next_st;

    logic [3:0] mode;
    logic       en;
    logic       spi_m;
    logic       spi_s;
    logic       i2c_s;
    logic       i2c_m;
    logic       use_ss;
    logic       valid_mode;
    logic       bus_idle;
    logic       wb_go;
    logic       wr_ctrl;
    logic       wr_buf;
    logic       wr_baud;
    logic       rd_buf;
    logic       busy;
    logic       idle_lvl;
    logic [8:0] half;
    logic       tick;
    logic       sdi_in;
    logic       push;
    logic [7:0] push_dat;
    logic       fifo_ready;
    logic       fifo_valid;
    logic [7:0] fifo_dat;

    //------------------------------------------------------------------
    // mode decode
    //------------------------------------------------------------------
    assign mode   = st.ctrl.port_mode_select;
    assign en     = st.ctrl.serial_port_enable;
    assign spi_m  = en && (mode == MODE_SPI_M4 || mode == MODE_SPI_M16 ||
                           mode == MODE_SPI_M64 || mode == MODE_SPI_MTMR ||
                           mode == MODE_SPI_MBRG);                   // [RQ8]
    assign spi_s  = en && (mode == MODE_SPI_S_SS || mode == MODE_SPI_S_IO); // [RQ9]
    assign use_ss = (mode == MODE_SPI_S_SS);                         // [RQ9]
    assign i2c_s  = en && (mode == MODE_I2C_S7 || mode == MODE_I2C_S10 ||
                           mode == MODE_I2C_S7E || mode == MODE_I2C_S10E); // [RQ10] [RQ11]
    assign i2c_m  = en && (mode == MODE_I2C_M);                      // [RQ12]
    // any other code leaves everything idle and the pins released
    assign valid_mode = spi_m || spi_s || i2c_s || i2c_m;            // [RQ16]

    assign o_spi_pins_own = spi_m || spi_s;                          // [RQ4]
    assign o_i2c_pins_own = i2c_s || i2c_m;                          // [RQ5]

    assign bus_idle = st.s2[PIN_SCL] && st.s2[PIN_SDA];
    assign busy     = (st.eng == ENG_RUN) || (spi_s && st.bitn != 3'h0);
    // I2C lines idle high; SPI idles at the polarity bit
    assign idle_lvl = i2c_m ? 1'b1 : st.ctrl.clock_polarity_hold;    // [RQ6] [RQ7]
    assign sdi_in   = i2c_m ? st.s2[PIN_SDA] : st.s2[PIN_SDI];

    //------------------------------------------------------------------
    // bus decode; a write lands at the edge that samples ack
    //------------------------------------------------------------------
    assign wb_go   = i_wb.cyc && i_wb.stb && st.ack;
    assign wr_ctrl = wb_go && i_wb.we && i_wb.sel[0] && i_wb.adr == ADR_CTRL;
    assign wr_buf  = wb_go && i_wb.we && i_wb.sel[0] && i_wb.adr == ADR_BUF;
    assign wr_baud = wb_go && i_wb.we && i_wb.sel[0] && i_wb.adr == ADR_BAUD;
    assign rd_buf  = i_wb.cyc && i_wb.stb && !st.ack && !i_wb.we &&
                     i_wb.adr == ADR_BUF;

    //------------------------------------------------------------------
    // master clock divider select
    //------------------------------------------------------------------
    always_comb
    begin
        case (mode)
            MODE_SPI_M4:  half = HALF_DIV4;
            MODE_SPI_M16: half = HALF_DIV16;
            MODE_SPI_M64: half = HALF_DIV64;
            // reload 0 still gives a clock of system clock /4 here; software must avoid it
            default:      half = {st.baud, 1'b0} + 9'h002;           // [RQ12] [RQ14] [RQ13]
        endcase
    end

    assign tick = (mode == MODE_SPI_MTMR) ? i_timer_tick              // [RQ8]
                                          : (st.divc == half - 9'h001);

    //------------------------------------------------------------------
    // next state
    //------------------------------------------------------------------
    always_comb
    begin
        next_st  = st;
        push     = 1'b0;
        push_dat = st.shreg;

        // pin synchronisers: s1 feeds only s2
        next_st.s1  = {i_sda, i_scl, i_ss_n, i_sdi, i_sck};
        next_st.s2  = st.s1;
        next_st.pv  = st.s2;
        next_st.evt = 1'b0;

        // answer one cycle after the request, drop ack the cycle after
        next_st.ack = i_wb.cyc && i_wb.stb && !st.ack;
        if (i_wb.cyc && i_wb.stb && !st.ack)
        begin
            case (i_wb.adr)
                ADR_CTRL: next_st.rdat = st.ctrl;
                ADR_BUF:  next_st.rdat = fifo_valid ? fifo_dat : 8'h00;
                ADR_BAUD: next_st.rdat = st.baud;
                ADR_STAT: next_st.rdat = {5'h00, bus_idle, fifo_valid, busy};
                default:  next_st.rdat = 8'h00;
            endcase
        end

        if (wr_baud)
            next_st.baud = i_wb.dat[7:0];

        // control write: flags only clear on zero, set elsewhere wins
        if (wr_ctrl)
        begin
            next_st.ctrl.serial_port_enable  = i_wb.dat[5];
            next_st.ctrl.clock_polarity_hold = i_wb.dat[4];
            next_st.ctrl.port_mode_select    = i_wb.dat[3:0];
            if (!i_wb.dat[7])
                next_st.ctrl.write_collision_flag = 1'b0;            // [RQ15]
            if (!i_wb.dat[6])
                next_st.ctrl.receive_overflow_flag = 1'b0;           // [RQ15]
        end

        // start and stop conditions on the I2C bus
        if (i2c_s && mode[3] && st.s2[PIN_SCL] && st.pv[PIN_SCL] &&
            st.s2[PIN_SDA] != st.pv[PIN_SDA])
            next_st.evt = 1'b1;                                      // [RQ11]

        // buffer write: start, load or collide
        if (wr_buf && valid_mode)
        begin
            if (busy || (i2c_m && !bus_idle))
                next_st.ctrl.write_collision_flag = 1'b1;            // [RQ1]
            else if (spi_m || i2c_m)
            begin
                // master transfers begin only here
                next_st.eng   = ENG_RUN;                             // [RQ3]
                next_st.shreg = i_wb.dat[7:0];
                next_st.sdo   = i_wb.dat[7];
                next_st.bitn  = 3'h0;
                next_st.divc  = 9'h000;
                next_st.sck   = idle_lvl;
            end
            else if (spi_s)
            begin
                next_st.shreg = i_wb.dat[7:0];
                next_st.sdo   = i_wb.dat[7];
            end
        end

        //--------------------------------------------------------------
        // master engine
        //--------------------------------------------------------------
        if (st.eng == ENG_RUN)
        begin
            if (!(spi_m || i2c_m))
                next_st.eng = ENG_IDLE;
            else
            begin
                next_st.divc = tick ? 9'h000 : st.divc + 9'h001;
                if (tick)
                begin
                    if (st.sck == idle_lvl)
                    begin
                        next_st.sck = ~st.sck;
                        next_st.smp = sdi_in;
                    end
                    else if (st.bitn == 3'h7 && !fifo_ready)
                    begin
                        // full buffer stalls the last edge, no overflow
                        next_st.divc = st.divc;                      // [RQ3]
                    end
                    else
                    begin
                        next_st.sck   = ~st.sck;
                        next_st.shreg = {st.shreg[6:0], st.smp};
                        next_st.sdo   = st.shreg[6];
                        next_st.bitn  = st.bitn + 3'h1;
                        if (st.bitn == 3'h7)
                        begin
                            push        = 1'b1;
                            push_dat    = {st.shreg[6:0], st.smp};
                            next_st.eng = ENG_IDLE;
                        end
                    end
                end
            end
        end

        //--------------------------------------------------------------
        // slave engine, clocked by the synchronised pin
        //--------------------------------------------------------------
        if (spi_s)
        begin
            if (use_ss && st.s2[PIN_SS])
                next_st.bitn = 3'h0;                                 // [RQ9]
            else if (st.s2[PIN_SCK] != st.pv[PIN_SCK])
            begin
                if (st.pv[PIN_SCK] == st.ctrl.clock_polarity_hold)
                    next_st.smp = st.s2[PIN_SDI];
                else
                begin
                    next_st.shreg = {st.shreg[6:0], st.smp};
                    next_st.sdo   = st.shreg[6];
                    next_st.bitn  = st.bitn + 3'h1;
                    if (st.bitn == 3'h7)
                    begin
                        push_dat = {st.shreg[6:0], st.smp};
                        if (fifo_ready)
                            push = 1'b1;
                        else
                            next_st.ctrl.receive_overflow_flag = 1'b1; // [RQ2]
                    end
                end
            end
        end
        else if (st.eng == ENG_IDLE)
        begin
            next_st.bitn = 3'h0;
            next_st.sck  = idle_lvl;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            st      <= '0;
            st.ctrl <= CTRL_RST;
            st.baud <= BAUD_RST;
        end
        else
            st <= next_st;
    end

    //------------------------------------------------------------------
    // receive buffer; popped by the read that is being answered
    //------------------------------------------------------------------
    ssc_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .i_clk       (i_clk),
        .i_sys_rst   (i_sys_rst),
        .i_in_valid  (push),
        .o_in_ready  (fifo_ready),
        .i_in_data   (push_dat),
        .o_out_valid (fifo_valid),
        .i_out_ready (rd_buf),
        .o_out_data  (fifo_dat)
    );

    //------------------------------------------------------------------
    // outputs
    //------------------------------------------------------------------
    assign o_wb_ack     = st.ack;
    assign o_wb_dat     = {24'h000000, st.rdat};
    assign o_port_event = st.evt;

    always_comb
    begin
        o_spi = '0;
        o_i2c = '0;
        if (spi_m)
        begin
            o_spi.sck    = (st.eng == ENG_RUN) ? st.sck : st.ctrl.clock_polarity_hold; // [RQ6]
            o_spi.sck_oe = 1'b1;                                     // [RQ4]
        end
        if (spi_m || (spi_s && !(use_ss && st.s2[PIN_SS])))
        begin
            o_spi.sdo    = st.sdo;
            o_spi.sdo_oe = 1'b1;                                     // [RQ4]
        end
        // open drain: enable pulls the line low
        if (i2c_s)
            o_i2c.scl_oe = !st.ctrl.clock_polarity_hold;             // [RQ7]
        if (i2c_m && st.eng == ENG_RUN)
        begin
            o_i2c.scl_oe = !st.sck;                                  // [RQ5]
            o_i2c.sda_oe = !st.sdo;
        end
    end

endmodule : ssc_port
